// file: logic/profiler_pkg.sv
// constants and types shared by the move profiler files
package profiler_pkg;
	localparam int          CLK_HZ         = 25000000;
	localparam logic [15:0] END_VEL_RST    = 16'h0FA0; // 4000 steps per second
	localparam logic [15:0] BEGIN_VEL_RST  = 16'h012C; // 300 steps per second
	localparam logic [15:0] SLOPE_RST      = 16'h000A; // 10 sps per step
	localparam logic [31:0] STD_MAX_TARGET = 32'h0000FFFE; // 65534
	localparam logic [31:0] WIDE_MAX_TGT   = 32'h7FFFFFFE; // 2,147,483,646
	localparam int          PULSE_NS       = 2000; // step pulse high time
	localparam int          PULSE_CYC      = (PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int          SETUP_NS       = 1000; // direction setup before pulse
	localparam int          SETUP_CYC      = (SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam int          DIV_BITS       = 32;
	typedef enum logic [2:0] {ST_IDLE, ST_DIVIDE, ST_PLAN, ST_SETUP, ST_PULSE, ST_GAP} move_state_t;
endpackage

// file: logic/step_divider_if.sv
// handshake bundle between the profiler and its serial divider
`timescale 1ns/1ps
interface step_divider_if;
	logic        start;
	logic [31:0] dividend;
	logic [31:0] divisor;
	logic        done;
	logic [31:0] quotient;
	modport master (output start, output dividend, output divisor, input done, input quotient);
	modport slave  (input start, input dividend, input divisor, output done, output quotient);
endinterface

// file: logic/serial_divider.sv
// restoring unsigned divider, one quotient bit per clock
`timescale 1ns/1ps
module serial_divider
(
	input  wire logic      clk,
	input  wire logic      reset,
	step_divider_if.slave  div
);
	logic [31:0] rem_reg;
	logic [31:0] quo_reg;
	logic [5:0]  cnt_reg;
	logic        busy_reg;
	logic        done_reg;
	logic [32:0] trial;
	logic [32:0] shifted;

	// shift in next dividend bit and try subtract
	assign shifted = {rem_reg, quo_reg[31]};
	assign trial   = shifted - {1'b0, div.divisor};
	assign div.done     = done_reg;
	assign div.quotient = quo_reg;

	// divide by zero yields all ones; caller never asks for it
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rem_reg  <= 32'h00000000;
			quo_reg  <= 32'h00000000;
			cnt_reg  <= 6'h00;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else if (div.start && !busy_reg)
		begin
			rem_reg  <= 32'h00000000;
			quo_reg  <= div.dividend;
			cnt_reg  <= 6'h20;
			busy_reg <= 1'b1;
			done_reg <= 1'b0;
		end
		else if (busy_reg)
		begin
			rem_reg  <= trial[32] ? shifted[31:0] : trial[31:0];
			quo_reg  <= {quo_reg[30:0], ~trial[32]};
			cnt_reg  <= cnt_reg - 6'h01;
			busy_reg <= (cnt_reg != 6'h01);
			done_reg <= (cnt_reg == 6'h01);
		end
		else
			done_reg <= 1'b0;
	end
endmodule

// file: logic/trapezoid_move_profiler.sv
// trapezoidal step and direction profile generator for one axis
// Function
// - each move starts at the beginning velocity and changes it by slope per step up, then down by slope per step.
// - velocity change is end velocity minus beginning velocity, or zero when end velocity is not above beginning velocity.
// - single ramp step count is velocity change divided by slope.
// - combined ramp step count is twice the single ramp count.
// - constant velocity steps are move length minus combined ramp count.
// - a short move never reaches end velocity and splits into half ramp up, half ramp down.
// - a zero slope gives a move with no ramps at the beginning velocity.
// - travel distance is the difference of position counter and target.
// - a higher target drives toward the limit end, a lower one toward home.
// - standard targets lie in 0..65534, at most 65534 steps per move.
// - wide option targets lie in +/-2,147,483,646.
// - a relative move overwrites the position counter then moves absolutely.
// - after a relative move the position counter reads zero.
// - a 32-bit signed accumulated position is kept and never cleared by relative moves.
// - after reset end velocity 4000, beginning velocity 300 and slope 10 are loaded.
`timescale 1ns/1ps
module trapezoid_move_profiler
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        wide_mode,
	input  wire logic        param_load,
	input  wire logic [15:0] end_vel_in,
	input  wire logic [15:0] begin_vel_in,
	input  wire logic [15:0] slope_in,
	input  wire logic        move_start,
	input  wire logic        move_relative,
	input  wire logic [31:0] move_target,
	output logic             move_ready,
	output logic             move_rejected,
	output logic             step_out,
	output logic             dir_out,
	output logic             busy,
	output logic [31:0]      position,
	output logic [31:0]      accumulated_position_register,
	output logic [15:0]      velocity
);
	step_divider_if div_bus();

	serial_divider u_div
	(
		.clk   (clk),
		.reset (reset),
		.div   (div_bus.slave)
	);

	profiler_pkg::move_state_t state_reg;
	logic [15:0] end_vel_reg;
	logic [15:0] begin_vel_reg;
	logic [15:0] slope_reg;
	logic [31:0] pos_reg;
	logic [31:0] acc_reg;
	logic [31:0] target_reg;
	logic [31:0] length_reg;
	logic [31:0] ramp_reg;
	logic [31:0] const_reg;
	logic [31:0] done_steps_reg;
	logic [15:0] vel_reg;
	logic        dir_reg;
	logic        step_reg;
	logic        rej_reg;
	logic        div_go_reg;
	logic [31:0] timer_reg;
	logic [31:0] pos_base;
	logic [31:0] target_base;
	logic [31:0] distance;
	logic        toward_limit;
	logic        target_ok;
	logic [31:0] vel_delta;
	logic [31:0] combined_ramp_steps;
	logic [31:0] move_length_steps;
	logic [31:0] half_len;
	logic [31:0] interval_cyc;
	logic [31:0] steps_left;
	logic        in_accel;
	logic        in_decel;
	logic [15:0] vel_next;

	function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
		return ($signed(a) > $signed(b)) ? a - b : b - a;
	endfunction

	// relative moves preload the counter with the negated distance and then run to zero;
	// the old counter content is lost on purpose, the accumulated count keeps the history
	assign pos_base     = move_relative ? 32'h00000000 - move_target : pos_reg;
	assign target_base  = move_relative ? 32'h00000000 : move_target;
	assign toward_limit = $signed(target_reg) > $signed(pos_reg);
	assign distance     = abs_diff(target_reg, pos_reg);
	assign move_length_steps = distance;
	assign target_ok    = wide_mode
		? ($signed(move_target) <= $signed(profiler_pkg::WIDE_MAX_TGT)
			&& $signed(move_target) >= -$signed(profiler_pkg::WIDE_MAX_TGT))
		: (move_target <= profiler_pkg::STD_MAX_TARGET);
	assign vel_delta    = (end_vel_reg > begin_vel_reg) ? {16'h0000, end_vel_reg - begin_vel_reg}
		: 32'h00000000;
	assign combined_ramp_steps = {ramp_reg[30:0], 1'b0};
	assign half_len     = {1'b0, move_length_steps[31:1]};
	assign steps_left   = length_reg - done_steps_reg;
	// step k of a ramp of r runs at begin + slope * min(k - 1, steps after it, r), so the
	// rate climbs while the done count is inside the ramp and short of the midpoint and
	// falls once the remaining count is inside the ramp and past it; never below begin
	assign in_accel     = (done_steps_reg <= ramp_reg) && (done_steps_reg < steps_left);
	assign in_decel     = (steps_left != 32'h00000000) && (steps_left <= ramp_reg)
		&& (steps_left < done_steps_reg);
	assign vel_next     = in_decel ? vel_reg - slope_reg
		: (in_accel ? vel_reg + slope_reg : vel_reg);
	assign interval_cyc = (vel_reg == 16'h0000) ? 32'(profiler_pkg::CLK_HZ)
		: 32'(profiler_pkg::CLK_HZ) / {16'h0000, vel_reg};

	assign div_bus.start    = div_go_reg;
	assign div_bus.dividend = vel_delta;
	assign div_bus.divisor  = {16'h0000, slope_reg};

	assign move_ready    = (state_reg == profiler_pkg::ST_IDLE);
	assign move_rejected = rej_reg;
	assign step_out      = step_reg;
	assign dir_out       = dir_reg;
	assign busy          = !move_ready;
	assign position      = pos_reg;
	assign accumulated_position_register = acc_reg;
	assign velocity      = vel_reg;

	// profile parameters with reset defaults
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			end_vel_reg   <= profiler_pkg::END_VEL_RST;
			begin_vel_reg <= profiler_pkg::BEGIN_VEL_RST;
			slope_reg     <= profiler_pkg::SLOPE_RST;
		end
		else if (param_load && move_ready)
		begin
			end_vel_reg   <= end_vel_in;
			begin_vel_reg <= begin_vel_in;
			slope_reg     <= slope_in;
		end
	end

	// move sequencer: divide, plan, then setup/pulse/gap per step
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg      <= profiler_pkg::ST_IDLE;
			pos_reg        <= 32'h00000000;
			acc_reg        <= 32'h00000000;
			target_reg     <= 32'h00000000;
			length_reg     <= 32'h00000000;
			ramp_reg       <= 32'h00000000;
			const_reg      <= 32'h00000000;
			done_steps_reg <= 32'h00000000;
			vel_reg        <= 16'h0000;
			dir_reg        <= 1'b0;
			step_reg       <= 1'b0;
			rej_reg        <= 1'b0;
			div_go_reg     <= 1'b0;
			timer_reg      <= 32'h00000000;
		end
		else
		begin
			rej_reg    <= 1'b0;
			div_go_reg <= 1'b0;
			case (state_reg)
				profiler_pkg::ST_IDLE:
				begin
					if (move_start && !target_ok)
						rej_reg <= 1'b1;
					else if (move_start)
					begin
						pos_reg    <= pos_base;
						target_reg <= target_base;
						div_go_reg <= (slope_reg != 16'h0000);
						state_reg  <= (slope_reg != 16'h0000) ? profiler_pkg::ST_DIVIDE
							: profiler_pkg::ST_PLAN;
						ramp_reg   <= 32'h00000000;
					end
				end
				profiler_pkg::ST_DIVIDE:
				begin
					if (div_bus.done)
					begin
						ramp_reg  <= div_bus.quotient;
						state_reg <= profiler_pkg::ST_PLAN;
					end
				end
				profiler_pkg::ST_PLAN:
				begin
					length_reg     <= move_length_steps;
					dir_reg        <= toward_limit;
					done_steps_reg <= 32'h00000000;
					vel_reg        <= begin_vel_reg;
					timer_reg      <= 32'(profiler_pkg::SETUP_CYC);
					// short move: ramps meet in the middle, top speed never reached
					if (move_length_steps < combined_ramp_steps)
					begin
						ramp_reg  <= half_len;
						const_reg <= 32'h00000000;
					end
					else
						const_reg <= move_length_steps - combined_ramp_steps;
					state_reg <= (move_length_steps == 32'h00000000) ? profiler_pkg::ST_IDLE
						: profiler_pkg::ST_SETUP;
				end
				profiler_pkg::ST_SETUP:
				begin
					// direction already settled, hold it through the pulse
					timer_reg <= timer_reg - 32'h00000001;
					if (timer_reg <= 32'h00000001)
					begin
						step_reg  <= 1'b1;
						timer_reg <= 32'(profiler_pkg::PULSE_CYC);
						state_reg <= profiler_pkg::ST_PULSE;
						pos_reg   <= dir_reg ? pos_reg + 32'h00000001 : pos_reg - 32'h00000001;
						acc_reg   <= dir_reg ? acc_reg + 32'h00000001 : acc_reg - 32'h00000001;
						done_steps_reg <= done_steps_reg + 32'h00000001;
					end
				end
				profiler_pkg::ST_PULSE:
				begin
					timer_reg <= timer_reg - 32'h00000001;
					if (timer_reg <= 32'h00000001)
					begin
						step_reg  <= 1'b0;
						// interval counted from setup start, so gap excludes pulse and setup
						timer_reg <= (interval_cyc > 32'(profiler_pkg::PULSE_CYC + profiler_pkg::SETUP_CYC))
							? interval_cyc - 32'(profiler_pkg::PULSE_CYC + profiler_pkg::SETUP_CYC)
							: 32'h00000001;
						state_reg <= profiler_pkg::ST_GAP;
					end
				end
				profiler_pkg::ST_GAP:
				begin
					timer_reg <= timer_reg - 32'h00000001;
					if (timer_reg <= 32'h00000001)
					begin
						vel_reg   <= vel_next;
						timer_reg <= 32'(profiler_pkg::SETUP_CYC);
						state_reg <= (steps_left == 32'h00000000) ? profiler_pkg::ST_IDLE
							: profiler_pkg::ST_SETUP;
					end
				end
				default:
					state_reg <= profiler_pkg::ST_IDLE;
			endcase
		end
	end

	// a relative move loads the counter with the negated distance and runs it up or down to
	// zero, so the counter reads zero once it ends; the host tracks absolute travel through
	// the accumulated count, which only reset clears

	// the gap after the final step running out
	sequence final_gap_s;
		state_reg == profiler_pkg::ST_GAP && timer_reg <= 32'h00000001 && steps_left == 32'h00000000;
	endsequence

	// a start that is taken, in range
	sequence accepted_start_s;
		move_ready && move_start && target_ok;
	endsequence

	// step pulse and direction timing at the driver pins
	step_pulse_width_a: assert property (@(posedge clk) disable iff (reset)
		$rose(step_reg) |-> step_reg [*2]) else $error("step pulse too short");
	dir_stable_a: assert property (@(posedge clk) disable iff (reset)
		step_reg |-> $stable(dir_reg)) else $error("direction moved during pulse");
	dir_choice_a: assert property (@(posedge clk) disable iff (reset)
		state_reg == profiler_pkg::ST_PLAN |=> dir_reg == toward_limit) else $error("direction not toward target");

	// counters
	pos_count_a: assert property (@(posedge clk) disable iff (reset)
		$rose(step_reg) |-> pos_reg == ($past(dir_reg) ? $past(pos_reg) + 32'h00000001
			: $past(pos_reg) - 32'h00000001)) else $error("position not one per step");
	acc_track_a: assert property (@(posedge clk) disable iff (reset)
		$rose(step_reg) |-> acc_reg - $past(acc_reg) == pos_reg - $past(pos_reg))
		else $error("accumulated position diverged");
	land_target_a: assert property (@(posedge clk) disable iff (reset)
		final_gap_s |=> move_ready && pos_reg == target_reg) else $error("move ended off target");

	// profile planning and velocity
	start_vel_a: assert property (@(posedge clk) disable iff (reset)
		state_reg == profiler_pkg::ST_PLAN |=> vel_reg == begin_vel_reg) else $error("move not at begin velocity");
	vel_bounds_a: assert property (@(posedge clk) disable iff (reset)
		step_reg |-> vel_reg >= begin_vel_reg && (vel_reg <= end_vel_reg || vel_reg == begin_vel_reg))
		else $error("velocity outside begin to end range");
	ramp_div_a: assert property (@(posedge clk) disable iff (reset)
		state_reg == profiler_pkg::ST_DIVIDE && div_bus.done |=>
		ramp_reg * {16'h0000, slope_reg} <= vel_delta) else $error("ramp count wrong");
	const_plan_a: assert property (@(posedge clk) disable iff (reset)
		state_reg == profiler_pkg::ST_PLAN && move_length_steps >= combined_ramp_steps
		|=> const_reg + $past(combined_ramp_steps) == length_reg) else $error("constant step count wrong");
	zero_slope_a: assert property (@(posedge clk) disable iff (reset)
		state_reg == profiler_pkg::ST_GAP && slope_reg == 16'h0000 |-> vel_next == vel_reg)
		else $error("ramp with zero slope");

	// target range and relative start
	reject_range_a: assert property (@(posedge clk) disable iff (reset)
		move_ready && move_start && !wide_mode && move_target > profiler_pkg::STD_MAX_TARGET
		|=> rej_reg && move_ready) else $error("out of range target accepted");
	reject_wide_a: assert property (@(posedge clk) disable iff (reset)
		move_ready && move_start && wide_mode && $signed(move_target) > $signed(profiler_pkg::WIDE_MAX_TGT)
		|=> rej_reg && move_ready) else $error("out of range wide target accepted");
	relative_base_a: assert property (@(posedge clk) disable iff (reset)
		accepted_start_s ##0 move_relative |=> pos_reg == 32'h00000000 - $past(move_target))
		else $error("relative move kept old counter");
endmodule

// file: testbench/stepper_driver_model.sv
// motor driver stand-in that counts step pulses by direction
`timescale 1ns/1ps
module stepper_driver_model
(
	input  wire logic   clk,
	input  wire logic   reset,
	input  wire logic   step_out,
	input  wire logic   dir_out,
	output logic [31:0] net_steps,
	output int          dir_faults
);
	logic step_reg;
	logic dir_reg;

	// one winding advance per rising step edge; a direction change on or during a pulse is a fault
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			step_reg   <= 1'b0;
			dir_reg    <= 1'b0;
			net_steps  <= 32'h00000000;
			dir_faults <= 0;
		end
		else
		begin
			step_reg <= step_out;
			dir_reg  <= dir_out;
			if (step_out && !step_reg)
				net_steps <= dir_out ? net_steps + 32'h00000001 : net_steps - 32'h00000001;
			if (step_out && dir_out != dir_reg)
				dir_faults <= dir_faults + 1;
		end
	end
endmodule

// file: testbench/trapezoid_move_profiler_bench.sv
// self-checking bench for the trapezoid move profiler
`timescale 1ns/1ps
module trapezoid_move_profiler_bench;
	logic        clk;
	logic        reset;
	logic        wide_mode;
	logic        param_load;
	logic [15:0] end_vel_in;
	logic [15:0] begin_vel_in;
	logic [15:0] slope_in;
	logic        move_start;
	logic        move_relative;
	logic [31:0] move_target;
	logic        move_ready;
	logic        move_rejected;
	logic        step_out;
	logic        dir_out;
	logic        busy;
	logic [31:0] position;
	logic [31:0] accumulated_position_register;
	logic [15:0] velocity;
	logic [31:0] net_steps;
	int          dir_faults;
	int          failures;
	int          n_compared;
	logic [15:0] vmax;
	logic [15:0] vmin;
	logic        seen;

	trapezoid_move_profiler dut_u (.clk(clk), .reset(reset), .wide_mode(wide_mode), .param_load(param_load),
		.end_vel_in(end_vel_in), .begin_vel_in(begin_vel_in), .slope_in(slope_in), .move_start(move_start),
		.move_relative(move_relative), .move_target(move_target), .move_ready(move_ready),
		.move_rejected(move_rejected), .step_out(step_out), .dir_out(dir_out), .busy(busy),
		.position(position), .accumulated_position_register(accumulated_position_register),
		.velocity(velocity));
	stepper_driver_model motor_u (.clk(clk), .reset(reset), .step_out(step_out), .dir_out(dir_out),
		.net_steps(net_steps), .dir_faults(dir_faults));

	// 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic final_report();
		$display("failures=%0d n_compared=%0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// a wait that ran out ends the run here
	task automatic give_up();
		failures++;
		final_report();
	endtask

	task automatic do_reset();
		@(posedge clk);
		reset <= 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		#1;
	endtask

	task automatic load_profile(input logic [15:0] e, input logic [15:0] b, input logic [15:0] s);
		@(posedge clk);
		param_load   <= 1'b1;
		end_vel_in   <= e;
		begin_vel_in <= b;
		slope_in     <= s;
		@(posedge clk);
		param_load <= 1'b0;
	endtask

	task automatic start_move(input logic [31:0] t, input logic rel);
		@(posedge clk);
		move_start    <= 1'b1;
		move_target   <= t;
		move_relative <= rel;
		@(posedge clk);
		move_start <= 1'b0;
	endtask

	// whole move, noting the slowest and fastest rate seen while stepping
	task automatic run_move(input logic [31:0] t, input logic rel);
		start_move(t, rel);
		vmax = 16'h0000;
		vmin = 16'hFFFF;
		for (int i = 0; i < 40000; i++)
		begin
			#1;
			if (busy === 1'b1 && velocity !== 16'h0000)
			begin
				if (velocity > vmax)
					vmax = velocity;
				if (velocity < vmin)
					vmin = velocity;
			end
			if (move_ready === 1'b1)
				return;
			@(posedge clk);
		end
		give_up();
	endtask

	task automatic try_reject(input logic [31:0] t);
		start_move(t, 1'b0);
		seen = 1'b0;
		repeat (3)
		begin
			#1;
			seen = seen | (move_rejected === 1'b1);
			check(busy, 32'h0);
			@(posedge clk);
		end
		check(seen, 32'h1);
	endtask

	task automatic sc_defaults();
		start_move(32'h00000005, 1'b0);
		for (int i = 0; velocity === 16'h0000; i++)
		begin
			if (i == 200)
				give_up();
			@(posedge clk);
			#1;
		end
		check(velocity, 32'h012C);
		check(dir_out, 32'h1);
		for (int i = 0; step_out !== 1'b1; i++)
		begin
			if (i == 200)
				give_up();
			@(posedge clk);
			#1;
		end
		check(position, 32'h1);
		do_reset();
		check(position, 32'h0);
		check(accumulated_position_register, 32'h0);
	endtask

	task automatic sc_ramps();
		load_profile(16'hEA60, 16'hC350, 16'h1388);
		run_move(32'h0000000A, 1'b0);
		check(position, 32'h0000000A);
		check(net_steps, 32'h0000000A);
		check(vmin, 32'hC350);
		check(vmax, 32'hEA60);
		run_move(32'h00000003, 1'b0);
		check(dir_out, 32'h0);
		check(position, 32'h00000003);
		check(net_steps, 32'h00000003);
		run_move(32'h00000005, 1'b0);
		check(vmax < 16'hEA60, 32'h1);
		check(position, 32'h00000005);
	endtask

	task automatic sc_flat_relative();
		load_profile(16'hEA60, 16'hC350, 16'h0000);
		run_move(32'h0000000D, 1'b0);
		check(vmax, 32'hC350);
		check(vmin, 32'hC350);
		run_move(32'h00000004, 1'b1);
		check(position, 32'h00000000);
		check(accumulated_position_register, 32'h00000011);
	endtask

	task automatic sc_range();
		try_reject(32'h0000FFFF);
		@(posedge clk);
		wide_mode <= 1'b1;
		try_reject(32'h7FFFFFFF);
		try_reject(32'h80000001);
		run_move(32'hFFFFFFFE, 1'b0);
		check(position, 32'hFFFFFFFE);
		check(accumulated_position_register, 32'h0000000F);
		check(net_steps, 32'h0000000F);
		check(dir_faults, 32'h0);
	endtask

	// main sequence
	initial
	begin
		failures      = 0;
		n_compared    = 0;
		reset         = 1'b1;
		wide_mode     = 1'b0;
		param_load    = 1'b0;
		end_vel_in    = 16'h0000;
		begin_vel_in  = 16'h0000;
		slope_in      = 16'h0000;
		move_start    = 1'b0;
		move_relative = 1'b0;
		move_target   = 32'h00000000;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		sc_defaults();
		sc_ramps();
		sc_flat_relative();
		sc_range();
		final_report();
	end
endmodule
